// file: hw/abu_pkg.sv
package abu_pkg;

   // ----------------------------------------------------------------
   // Register map (printed offsets are not all multiples of four,
   // so each is an index and the byte address is four times it)
   // ----------------------------------------------------------------
   localparam logic [15:0] ABU_IDX_ADDR_HIGH = 16'hfe0c;
   localparam logic [15:0] ABU_IDX_ADDR_LOW = 16'hfe0d;
   localparam logic [15:0] ABU_IDX_CTRL = 16'hfe0e;
   localparam logic [15:0] ABU_IDX_FLAG_CTRL = 16'hfe0f;
   localparam logic [15:0] ABU_IDX_SYS_STATUS = 16'hfe10;
   localparam logic [15:0] ABU_IDX_IRQ_STATUS = 16'hfe11;
   localparam logic [15:0] ABU_IDX_IRQ_MASK = 16'hfe12;

   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int ABU_BIT_MATCH_EN = 7;
   localparam int ABU_BIT_ACTIVE = 6;
   localparam int ABU_BIT_CLR_EN = 7;
   localparam int ABU_BIT_WAIT_EXIT = 1;
   localparam int ABU_EV_BREAK = 0;
   localparam int ABU_EV_WAKE = 1;
   localparam int ABU_EV_END = 2;
   localparam int ABU_NUM_EV = 3;
   localparam logic [7:0] ABU_BYTE_RST = 8'h00;
   localparam logic [ABU_NUM_EV-1:0] ABU_EV_RST = 3'h0;

   // ----------------------------------------------------------------
   // Break vectors
   // ----------------------------------------------------------------
   localparam logic [15:0] ABU_VEC_USER = 16'hfffc;
   localparam logic [15:0] ABU_VEC_MONITOR = 16'hfefc;
   localparam logic [7:0] ABU_SOFT_INT_OPCODE = 8'h83;

   typedef enum logic [1:0] {
      ABU_IDLE,
      ABU_PENDING,
      ABU_IN_BREAK
   } abu_state_type;

   // Request from the CPU sequencer
   typedef struct packed {
      logic [15:0] addr;
      logic addr_valid;
      logic last_cycle;
      logic ret_from_int;
      logic wait_mode;
      logic stop_mode;
      logic monitor_mode;
      logic high_test_voltage;
   } abu_cpu_in_type;

   // Answer to the CPU and chip-side controls
   typedef struct packed {
      logic break_req;
      logic force_opcode;
      logic [7:0] opcode;
      logic [15:0] vector;
      logic in_break;
      logic timer_freeze;
      logic watchdog_disable;
      logic status_clear_allow;
      logic stop_wake;
   } abu_cpu_out_type;

   typedef struct packed {
      abu_state_type state;
      logic [7:0] addr_high;
      logic [7:0] addr_low;
      logic match_en;
      logic active;
      logic clr_en;
      logic wait_exit;
      logic [ABU_NUM_EV-1:0] irq_status;
      logic [ABU_NUM_EV-1:0] irq_mask;
      logic [31:0] prdata;
      logic was_wait;
      logic was_stop;
      logic ack;
   } abu_state_regs_type;

endpackage : abu_pkg

// file: hw/abu_break_unit.sv
// Local design decision: the APB slave port.
`timescale 1ns/10ps
module abu_break_unit
   import abu_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [17:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // CPU side
   input wire abu_cpu_in_type cpu_in,
   output abu_cpu_out_type cpu_out,
   // Interrupt
   output logic irq
);

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   localparam int ABU_ADDR_LSB = 2;

   abu_state_regs_type state_reg;
   abu_state_regs_type state_next;
   logic [15:0] idx;
   logic access;
   logic wr;
   logic rd;
   logic mapped;
   logic lane0;
   logic [7:0] wbyte;
   logic match;
   logic sw_break;
   logic trigger;
   logic enter_now;
   logic wake;
   logic [ABU_NUM_EV-1:0] events;

   assign idx = paddr[17:ABU_ADDR_LSB];
   assign access = psel && penable;
   // Writes land on the completing edge; reads are captured one
   // cycle earlier so registered data stands while pready is high
   assign wr = access && pwrite && state_reg.ack;
   assign rd = access && !pwrite && !state_reg.ack;
   assign lane0 = pstrb[0];
   assign wbyte = pwdata[7:0];
   assign mapped = (idx == ABU_IDX_ADDR_HIGH) || (idx == ABU_IDX_ADDR_LOW) ||
                   (idx == ABU_IDX_CTRL) || (idx == ABU_IDX_FLAG_CTRL) ||
                   (idx == ABU_IDX_SYS_STATUS) ||
                   (idx == ABU_IDX_IRQ_STATUS) || (idx == ABU_IDX_IRQ_MASK);
   // One wait state: every access completes in its second access cycle
   assign pready = state_reg.ack;
   assign pslverr = access && !mapped;
   assign prdata = state_reg.prdata;

   // ----------------------------------------------------------------
   // Break detection
   // ----------------------------------------------------------------
   // Comparator gated off in stop mode; stop itself leaves state alone
   assign match = state_reg.match_en && cpu_in.addr_valid &&
                  !cpu_in.stop_mode &&
                  (cpu_in.addr == {state_reg.addr_high,
                                   state_reg.addr_low});
   assign sw_break = wr && lane0 && (idx == ABU_IDX_CTRL) &&
                     wbyte[ABU_BIT_ACTIVE] &&
                     !state_reg.active;
   assign trigger = (match || sw_break) && (state_reg.state == ABU_IDLE);
   assign enter_now = cpu_in.last_cycle;
   // A match or a software break can wake from wait; the comparator is gated off
   // in stop, so only a software break can wake from stop
   assign wake = trigger && (cpu_in.wait_mode || cpu_in.stop_mode);

   always_comb begin
      state_next = state_reg;
      events = '0;
      events[ABU_EV_BREAK] = trigger;
      events[ABU_EV_WAKE] = wake;
      state_next.ack = access && !state_reg.ack;

      // --------------------------------------------------------------
      // Break sequencing
      // --------------------------------------------------------------
      case (state_reg.state)
         ABU_IDLE: begin
            if (trigger) begin
               state_next.state = enter_now ? ABU_IN_BREAK : ABU_PENDING;
            end
         end
         ABU_PENDING: begin
            // Hold the request until the current instruction finishes
            if (cpu_in.last_cycle) begin
               state_next.state = ABU_IN_BREAK;
            end
         end
         ABU_IN_BREAK: begin
            if (cpu_in.ret_from_int) begin
               state_next.state = ABU_IDLE;
               events[ABU_EV_END] = 1'b1;
            end
         end
         default: begin
            state_next.state = ABU_IDLE;
         end
      endcase

      // --------------------------------------------------------------
      // Register writes
      // --------------------------------------------------------------
      if (wr && lane0) begin
         case (idx)
            ABU_IDX_ADDR_HIGH: state_next.addr_high = wbyte;
            ABU_IDX_ADDR_LOW: state_next.addr_low = wbyte;
            ABU_IDX_CTRL: begin
               state_next.match_en = wbyte[ABU_BIT_MATCH_EN];
               state_next.active = wbyte[ABU_BIT_ACTIVE];
            end
            ABU_IDX_FLAG_CTRL: state_next.clr_en = wbyte[ABU_BIT_CLR_EN];
            ABU_IDX_SYS_STATUS: begin
               // Write zero clears and write one is ignored, unlike the active bit
               if (!wbyte[ABU_BIT_WAIT_EXIT]) begin
                  state_next.wait_exit = 1'b0;
               end
            end
            ABU_IDX_IRQ_STATUS: begin
               state_next.irq_status = state_reg.irq_status &
                                       ~wbyte[ABU_NUM_EV-1:0];
            end
            ABU_IDX_IRQ_MASK: state_next.irq_mask = wbyte[ABU_NUM_EV-1:0];
            default: begin
            end
         endcase
      end

      // Hardware sets win over software clears
      if (match) begin
         state_next.active = 1'b1;
      end
      if (wake) begin
         state_next.wait_exit = 1'b1;
      end
      state_next.irq_status = state_next.irq_status | events;
      state_next.was_wait = cpu_in.wait_mode;
      state_next.was_stop = cpu_in.stop_mode;

      // --------------------------------------------------------------
      // Read data, captured in the access cycle
      // --------------------------------------------------------------
      state_next.prdata = '0;
      if (rd) begin
         case (idx)
            ABU_IDX_ADDR_HIGH: state_next.prdata[7:0] = state_reg.addr_high;
            ABU_IDX_ADDR_LOW: state_next.prdata[7:0] = state_reg.addr_low;
            ABU_IDX_CTRL: begin
               state_next.prdata[ABU_BIT_MATCH_EN] = state_reg.match_en;
               state_next.prdata[ABU_BIT_ACTIVE] = state_reg.active;
            end
            ABU_IDX_FLAG_CTRL: begin
               state_next.prdata[ABU_BIT_CLR_EN] = state_reg.clr_en;
            end
            ABU_IDX_SYS_STATUS: begin
               state_next.prdata[ABU_BIT_WAIT_EXIT] = state_reg.wait_exit;
            end
            ABU_IDX_IRQ_STATUS: begin
               state_next.prdata[ABU_NUM_EV-1:0] = state_reg.irq_status;
            end
            ABU_IDX_IRQ_MASK: begin
               state_next.prdata[ABU_NUM_EV-1:0] = state_reg.irq_mask;
            end
            default: begin
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Read data is registered in the first access cycle and stands
   // through the second, in which pready is high
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg.state <= ABU_IDLE;
         state_reg.addr_high <= ABU_BYTE_RST;
         state_reg.addr_low <= ABU_BYTE_RST;
         state_reg.match_en <= 1'b0;
         state_reg.active <= 1'b0;
         state_reg.clr_en <= 1'b0;
         state_reg.wait_exit <= 1'b0;
         state_reg.irq_status <= ABU_EV_RST;
         state_reg.irq_mask <= ABU_EV_RST;
         state_reg.prdata <= '0;
         state_reg.was_wait <= 1'b0;
         state_reg.was_stop <= 1'b0;
         state_reg.ack <= 1'b0;
      end else begin
         state_reg <= state_next;
      end
   end

   // ----------------------------------------------------------------
   // CPU outputs
   // ----------------------------------------------------------------
   logic in_break;
   assign in_break = (state_reg.state == ABU_IN_BREAK);

   always_comb begin
      cpu_out = '0;
      cpu_out.break_req = (state_reg.state == ABU_PENDING) ||
                          (trigger && enter_now);
      cpu_out.force_opcode = cpu_out.break_req && cpu_in.last_cycle;
      cpu_out.opcode = ABU_SOFT_INT_OPCODE;
      cpu_out.vector = cpu_in.monitor_mode ? ABU_VEC_MONITOR
                                           : ABU_VEC_USER;
      cpu_out.in_break = in_break;
      cpu_out.timer_freeze = in_break;
      cpu_out.watchdog_disable = in_break &&
                                 cpu_in.high_test_voltage;
      cpu_out.status_clear_allow = !in_break || state_reg.clr_en;
      cpu_out.stop_wake = wake && cpu_in.stop_mode;
   end

   assign irq = |(state_reg.irq_status & state_reg.irq_mask);

endmodule : abu_break_unit

// file: dv/abu_assertions.sv
`timescale 1ns/10ps
module abu_assertions
   import abu_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [17:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   // CPU side
   input wire abu_cpu_in_type cpu_in,
   input wire abu_cpu_out_type cpu_out
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic acc;
   assign acc = psel && penable;
   a_vec_select: assert property (cpu_out.break_req |-> cpu_out.vector ==
      (cpu_in.monitor_mode ? ABU_VEC_MONITOR : ABU_VEC_USER))
      else $error("wrong break vector");
   a_force_cause: assert property (cpu_out.force_opcode |-> cpu_out.break_req
      && cpu_in.last_cycle && cpu_out.opcode == ABU_SOFT_INT_OPCODE)
      else $error("opcode forced without cause");
   a_break_enter: assert property (cpu_out.force_opcode |=> cpu_out.in_break
      [*2]) else $error("break not entered");
   a_rti_exit: assert property (cpu_out.in_break && cpu_in.ret_from_int |=>
      !cpu_out.in_break) else $error("return did not end break");
   a_timer_halt: assert property (cpu_out.timer_freeze == cpu_out.in_break)
      else $error("timer freeze wrong");
   a_wdog_off: assert property (cpu_out.watchdog_disable == (cpu_out.in_break
      && cpu_in.high_test_voltage)) else $error("watchdog gate wrong");
   a_clear_free: assert property (!cpu_out.in_break |->
      cpu_out.status_clear_allow) else $error("clear blocked");
   a_read_clean: assert property (!(acc && !pwrite) |=> prdata == 32'h0)
      else $error("read data not cleared");
   a_err_map: assert property (acc |-> pslverr == (paddr[17:2] <
      ABU_IDX_ADDR_HIGH || paddr[17:2] > ABU_IDX_IRQ_MASK))
      else $error("error response wrong");
   c_force: cover property (cpu_out.force_opcode);
   c_monitor: cover property (cpu_out.in_break && cpu_in.monitor_mode);
   c_rti: cover property (cpu_out.in_break && cpu_in.ret_from_int);
endmodule : abu_assertions

bind abu_break_unit abu_assertions u_chk (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .prdata, .pslverr, .cpu_in, .cpu_out);

// file: dv/abu_cpu_model.sv
`timescale 1ns/10ps
module abu_cpu_model
   import abu_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Bench control
   input wire logic run,
   input wire logic ret_req,
   input wire logic load,
   input wire logic [15:0] start_pc,
   input wire abu_cpu_in_type modes,
   // Break unit
   input wire abu_cpu_out_type cpu_out,
   output abu_cpu_in_type cpu_in
);
   // Two-cycle instructions; fetch stops while halted or in break
   logic [15:0] pc;
   logic ph;
   logic live;
   // Not live while loading, so a stale address cannot match
   assign live = run && !load && !cpu_out.in_break;
   always_comb begin
      cpu_in = modes;
      // Idle bus shows the inverse so a stale match cannot hide
      cpu_in.addr = live ? pc : ~pc;
      cpu_in.addr_valid = live;
      cpu_in.last_cycle = live && ph;
      cpu_in.ret_from_int = cpu_out.in_break && ret_req;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc <= 16'h0000;
         ph <= 1'b0;
      end else if (load) begin
         pc <= start_pc;
         ph <= modes.last_cycle;
      end else if (live) begin
         ph <= !ph;
         if (ph) begin
            pc <= pc + 16'h0001;
         end
      end
   end
endmodule : abu_cpu_model

// file: dv/abu_break_unit_tb_top.sv
`timescale 1ns/10ps
module abu_break_unit_tb_top;
   import abu_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [17:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic [3:0] pstrb = 4'hf;
   logic pready, pslverr, irq, err, run = 0, ret_req = 0, load = 0;
   logic [15:0] start_pc = 0;
   abu_cpu_in_type modes = '0, cpu_in;
   abu_cpu_out_type cpu_out;
   int errors = 0, tests_run = 0, n;
   always #12.5 pclk = ~pclk;
   abu_break_unit DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .pstrb, .prdata, .pready, .pslverr, .cpu_in, .cpu_out, .irq);
   abu_cpu_model cpu (.pclk, .presetn, .run, .ret_req, .load, .start_pc,
      .modes, .cpu_out, .cpu_in);
   task summarize;
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : summarize
   task chk(input string what, input logic [31:0] exp, got);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("wrong value %s exp %h got %h", what, exp, got);
      end
   endtask : chk
   // ----------------------------------------------------------------
   // APB master; read data taken at the edge where pready is high
   // ----------------------------------------------------------------
   task apb(input logic w, input logic [15:0] idx, input logic [7:0] d);
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      err = pslverr;
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
      if (n >= 50) begin
         errors++;
         summarize();
      end
   endtask : apb
   task rdchk(input logic [15:0] idx, input logic [7:0] exp);
      apb(1'b0, idx, 8'h00);
      chk($sformatf("reg %h", idx), {24'h0, exp}, rd);
   endtask : rdchk
   task wait_brk(input logic v);
      n = 0;
      while (cpu_out.in_break !== v && n < 100) begin
         @(posedge pclk);
         #1 n++;
      end
      if (n >= 100) begin
         errors++;
         summarize();
      end
   endtask : wait_brk
   task go(input logic [15:0] pc, input logic ph);
      @(posedge pclk);
      start_pc <= pc;
      modes.last_cycle <= ph;
      load <= 1'b1;
      run <= 1'b1;
      @(posedge pclk);
      load <= 1'b0;
   endtask : go
   task finish_brk;
      apb(1'b1, ABU_IDX_CTRL, 8'h80);
      @(posedge pclk);
      ret_req <= 1'b1;
      wait_brk(1'b0);
      @(posedge pclk);
      ret_req <= 1'b0;
   endtask : finish_brk
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      rdchk(ABU_IDX_ADDR_HIGH, 8'h00);
      rdchk(ABU_IDX_ADDR_LOW, 8'h00);
      rdchk(ABU_IDX_CTRL, 8'h00);
      apb(1'b0, 16'hfe13, 8'h00);
      chk("unmapped error", 1, err);
      $display("test reset done");
      apb(1'b1, ABU_IDX_ADDR_HIGH, 8'h12);
      apb(1'b1, ABU_IDX_ADDR_LOW, 8'h34);
      apb(1'b1, ABU_IDX_IRQ_MASK, 8'h01);
      apb(1'b1, ABU_IDX_CTRL, 8'h80);
      go(16'h1230, 1'b0);
      wait_brk(1'b1);
      chk("timer freeze", 1, cpu_out.timer_freeze);
      chk("clear allow", 0, cpu_out.status_clear_allow);
      chk("irq", 1, irq);
      rdchk(ABU_IDX_CTRL, 8'hc0);
      rdchk(ABU_IDX_IRQ_STATUS, 8'h01);
      apb(1'b1, ABU_IDX_FLAG_CTRL, 8'h80);
      chk("clear allow", 1, cpu_out.status_clear_allow);
      finish_brk();
      rdchk(ABU_IDX_CTRL, 8'h80);
      apb(1'b1, ABU_IDX_IRQ_MASK, 8'h00);
      chk("irq masked", 0, irq);
      apb(1'b1, ABU_IDX_IRQ_STATUS, 8'h07);
      rdchk(ABU_IDX_IRQ_STATUS, 8'h00);
      $display("test address match done");
      apb(1'b1, ABU_IDX_CTRL, 8'h00);
      go(16'h1230, 1'b0);
      repeat (20) begin
         @(posedge pclk);
         #1 chk("no break", 0, cpu_out.in_break);
      end
      apb(1'b1, ABU_IDX_CTRL, 8'h80);
      go(16'h1234, 1'b1);
      wait_brk(1'b1);
      finish_brk();
      $display("test enable and last cycle done");
      for (int m = 0; m < 3; m++) begin
         @(posedge pclk);
         modes.monitor_mode <= (m == 0);
         modes.high_test_voltage <= (m == 0);
         modes.wait_mode <= (m == 1);
         modes.stop_mode <= (m == 2);
         run <= (m == 0);
         rdchk(ABU_IDX_ADDR_HIGH, 8'h12);
         apb(1'b1, ABU_IDX_CTRL, 8'hc0);
         @(posedge pclk);
         modes.wait_mode <= 1'b0;
         modes.stop_mode <= 1'b0;
         run <= 1'b1;
         wait_brk(1'b1);
         chk("vector", m ? ABU_VEC_USER : ABU_VEC_MONITOR, cpu_out.vector);
         chk("watchdog off", m == 0, cpu_out.watchdog_disable);
         rdchk(ABU_IDX_SYS_STATUS, m ? 8'h02 : 8'h00);
         apb(1'b1, ABU_IDX_SYS_STATUS, 8'h00);
         finish_brk();
         if (m == 1) go(16'h1300, 1'b0);
      end
      $display("test software break done");
      summarize();
   end
endmodule : abu_break_unit_tb_top
